// File: rtl/tbd_chan_buf.sv
`default_nettype none
module tbd_chan_buf
  import tbd_pkg::*;
#(
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             oct_tog_i,
  input  wire logic [OCT_W-1:0] oct_i,
  input  wire logic [SIG_W-1:0] sig_i,
  input  wire logic [TS_W-1:0]  ts_i,
  input  wire logic             line_clk_i,
  output logic                  data_o,
  output logic [SIG_W-1:0]      sig_o,
  output logic                  frame_o,
  output logic                  overflow_o
);
  localparam int unsigned ENT_W = TS_W + SIG_W + OCT_W;
  localparam int unsigned PTR_W = $clog2(DEPTH);

  // ==========================================================================
  // crossings: toggle for the octet event, three flops for the line clock
  logic [2:0] tog_q, tog_d, lck_q, lck_d;
  logic       wr, edge_l;
  always_comb begin
    tog_d  = {tog_q[1:0], oct_tog_i};
    lck_d  = {lck_q[1:0], line_clk_i};
    wr     = tog_q[2] ^ tog_q[1];
    edge_l = lck_q[1] & ~lck_q[2];
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tog_q <= 3'h0;
      lck_q <= 3'h0;
    end else begin
      tog_q <= tog_d;
      lck_q <= lck_d;
    end
  end

  // ==========================================================================
  // octet buffer and serializer
  logic [ENT_W-1:0] mem_q [DEPTH];
  logic [ENT_W-1:0] mem_d [DEPTH];
  logic [PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PTR_W:0]   cnt_q, cnt_d;
  logic [OCT_W-1:0] sr_q, sr_d;
  logic [2:0]       left_q, left_d;
  logic             out_q, out_d, frm_q, frm_d, ovf_q, ovf_d, full, empty, push, pop;
  logic [SIG_W-1:0] sigo_q, sigo_d;
  logic [ENT_W-1:0] head;
  always_comb begin
    mem_d  = mem_q;
    full   = (cnt_q == (PTR_W+1)'(DEPTH));
    empty  = (cnt_q == '0);
    head   = mem_q[rp_q];
    push   = wr & ~full;                                    // R16
    pop    = edge_l & (left_q == 3'h0) & ~empty;
    ovf_d  = wr & full;
    wp_d   = push ? PTR_W'(wp_q + 1'b1) : wp_q;
    rp_d   = pop ? PTR_W'(rp_q + 1'b1) : rp_q;
    cnt_d  = (PTR_W+1)'(cnt_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop});
    if (push) begin
      mem_d[wp_q] = {ts_i, sig_i, oct_i};
    end
    sr_d   = sr_q;
    left_d = left_q;
    out_d  = out_q;
    frm_d  = frm_q;
    sigo_d = sigo_q;
    if (edge_l) begin                                       // R9
      if (left_q != 3'h0) begin
        out_d  = sr_q[OCT_W-1];
        sr_d   = {sr_q[OCT_W-2:0], 1'b0};
        left_d = 3'(left_q - 1'b1);
      end else if (!empty) begin
        out_d  = head[OCT_W-1];
        sr_d   = {head[OCT_W-2:0], 1'b0};
        left_d = LAST_BIT;
        sigo_d = head[OCT_W +: SIG_W];
        frm_d  = (head[OCT_W+SIG_W +: TS_W] == TS_FRAME);
      end else begin
        // underrun: line sees idle ones rather than stale payload
        out_d  = IDLE_BIT;
        frm_d  = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      sr_q   <= '0;
      left_q <= 3'h0;
      out_q  <= IDLE_BIT;
      frm_q  <= 1'b0;
      ovf_q  <= 1'b0;
      sigo_q <= '0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      sr_q   <= sr_d;
      left_q <= left_d;
      out_q  <= out_d;
      frm_q  <= frm_d;
      ovf_q  <= ovf_d;
      sigo_q <= sigo_d;
    end
  end
  always_ff @(posedge clk_i) begin
    mem_q <= mem_d;
  end

  assign data_o     = out_q;
  assign sig_o      = sigo_q;
  assign frame_o    = frm_q;
  assign overflow_o = ovf_q;

  // ==========================================================================
  chk_line_shift: assert property (@(posedge clk_i) disable iff (srst_i) // R9
    edge_l && left_q != 3'h0 |=> left_q == $past(left_q) - 3'h1 && out_q == $past(sr_q[7]))
    else $error("line bit not shifted on line clock edge");
  chk_buf_full: assert property (@(posedge clk_i) disable iff (srst_i) // R16
    wr && full && !pop |=> cnt_q == (PTR_W+1)'(DEPTH) && overflow_o)
    else $error("full buffer accepted an octet");
endmodule
`default_nettype wire

// File: rtl/tbd_demux.sv
`default_nettype none
// Behaviour
// R1 - mux enable one with mode 01 selects bit-multiplexed capture at 16.384 MHz.
// R2 - sender interleaves four channels bit by bit, payload bits one to four twice, channel 0 first.
// R3 - payload bits five to eight are sent once, each followed by signaling bit A to D.
// R4 - later octets follow the same interleaving and signaling scheme.
// R5 - the group sync is high for one cycle at the first bit of the stream.
// R6 - the sync pulse is sampled and fixes the start of the multiplexed frame.
// R7 - the sender aligns data to sync; the block does no realignment.
// R8 - filler and duplicate slots are dropped; payload and signaling go to each channel.
// R9 - each channel's free-running line clock moves its payload out of the block.
// R10 - mux enable one with mode 10 selects byte-interleaved capture at 16.384 MHz.
// R11 - the stream for a group of four channels enters on a single data pin.
// R12 - the sender drives a free-running 16.384 MHz clock and launches data on its rise.
// R13 - each serial bit is captured on the falling edge of the high-speed input clock.
// R14 - the sender maps four 2.048 Mbit/s streams into the 16.384 Mbit/s stream.
// R15 - byte-interleaved: each timeslot bit is sent twice, channel by channel.
// R16 - one copy of each doubled bit is kept and octets are buffered per channel.
module tbd_demux
  import tbd_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  tx_mux_enable_i,
  input  wire logic [1:0]            tx_if_mode_i,
  input  wire logic                  tx_highspeed_input_clock_i,
  input  wire logic                  tx_serial_data_in_i,
  input  wire logic                  tx_frame_sync_in_i,
  input  wire logic [CH_N-1:0]       per_channel_tx_line_clock_i,
  output logic      [CH_N-1:0]       tx_line_data_o,
  output logic      [CH_N*SIG_W-1:0] tx_line_sig_o,
  output logic      [CH_N-1:0]       tx_line_frame_o,
  output logic      [CH_N-1:0]       tx_overflow_o
);
  // ==========================================================================
  // link domain reset and configuration, two flops each
  // mode bits are quasi-static, so a per-bit synchroniser is acceptable
  logic [1:0] rst_sq;
  logic [2:0] cfg_m_q, cfg_q;
  logic       rst_l;
  always_ff @(negedge tx_highspeed_input_clock_i) begin
    rst_sq  <= {rst_sq[0], srst_i};
    cfg_m_q <= {tx_mux_enable_i, tx_if_mode_i};
    cfg_q   <= cfg_m_q;
  end
  assign rst_l = rst_sq[1];

  // ==========================================================================
  // stream position and slot decode, all on the falling edge
  logic [POS_W-1:0] cnt_q, cnt_d, pos;
  logic             bm, hm, keep_pay, keep_sig, done;
  logic [CH_W-1:0]  ch;
  logic [2:0]       bitp;
  always_comb begin
    bm       = cfg_q[2] & (cfg_q[1:0] == MODE_BITMUX);       // R1
    hm       = cfg_q[2] & (cfg_q[1:0] == MODE_HMVIP);        // R10
    pos      = tx_frame_sync_in_i ? '0 : cnt_q;              // R6
    cnt_d    = POS_W'(pos + 1'b1);
    ch       = '0;
    bitp     = '0;
    keep_pay = 1'b0;
    keep_sig = 1'b0;
    done     = 1'b0;
    if (bm) begin
      ch       = pos[BM_CH_LSB +: CH_W];
      bitp     = pos[BM_BIT_LSB +: 3];
      keep_pay = ~pos[0];                                    // R8
      keep_sig = pos[0] & pos[SIG_BIT];                      // R8
      done     = keep_sig & (bitp == LAST_BIT);
    end else if (hm) begin
      ch       = pos[HM_CH_LSB +: CH_W];
      bitp     = pos[HM_BIT_LSB +: 3];
      keep_pay = ~pos[0];                                    // R16
      done     = keep_pay & (bitp == LAST_BIT);
    end
  end

  // ==========================================================================
  // per-channel assembly and hand-over words
  logic [OCT_W-1:0] sh_q [CH_N];
  logic [OCT_W-1:0] sh_d [CH_N];
  logic [SIG_W-1:0] sg_q [CH_N];
  logic [SIG_W-1:0] sg_d [CH_N];
  logic [OCT_W-1:0] oc_q [CH_N];
  logic [OCT_W-1:0] oc_d [CH_N];
  logic [SIG_W-1:0] os_q [CH_N];
  logic [SIG_W-1:0] os_d [CH_N];
  logic [TS_W-1:0]  ot_q [CH_N];
  logic [TS_W-1:0]  ot_d [CH_N];
  logic [CH_N-1:0]  tg_q, tg_d;
  always_comb begin
    sh_d = sh_q;
    sg_d = sg_q;
    oc_d = oc_q;
    os_d = os_q;
    ot_d = ot_q;
    tg_d = tg_q;
    if (keep_pay) begin
      sh_d[ch] = {sh_q[ch][OCT_W-2:0], tx_serial_data_in_i};  // R13
    end
    if (keep_sig) begin
      sg_d[ch] = {sg_q[ch][SIG_W-2:0], tx_serial_data_in_i};
    end
    if (done) begin                                          // R8
      oc_d[ch] = sh_d[ch];
      os_d[ch] = hm ? '0 : sg_d[ch];
      ot_d[ch] = pos[TS_LSB +: TS_W];
      tg_d[ch] = ~tg_q[ch];
    end
  end
  always_ff @(negedge tx_highspeed_input_clock_i) begin
    if (rst_l) begin
      cnt_q <= '0;
      tg_q  <= '0;
      for (int i = 0; i < CH_N; i++) begin
        sh_q[i] <= '0;
        sg_q[i] <= '0;
        oc_q[i] <= '0;
        os_q[i] <= '0;
        ot_q[i] <= '0;
      end
    end else begin
      cnt_q <= cnt_d;
      tg_q  <= tg_d;
      sh_q  <= sh_d;
      sg_q  <= sg_d;
      oc_q  <= oc_d;
      os_q  <= os_d;
      ot_q  <= ot_d;
    end
  end

  // ==========================================================================
  // system-clock side: one buffer per channel, drained by its line clock
  // held words stay stable for 64 link cycles, far longer than the crossing
  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    tbd_chan_buf #(
      .DEPTH (BUF_DEPTH)
    ) u_buf (
      .clk_i      (clk_i),
      .srst_i     (srst_i),
      .oct_tog_i  (tg_q[g]),
      .oct_i      (oc_q[g]),
      .sig_i      (os_q[g]),
      .ts_i       (ot_q[g]),
      .line_clk_i (per_channel_tx_line_clock_i[g]),                 // R9
      .data_o     (tx_line_data_o[g]),
      .sig_o      (tx_line_sig_o[g*SIG_W +: SIG_W]),
      .frame_o    (tx_line_frame_o[g]),
      .overflow_o (tx_overflow_o[g])
    );
  end

  // ==========================================================================
  chk_sync_align: assert property (@(negedge tx_highspeed_input_clock_i) // R6
    disable iff (rst_l) tx_frame_sync_in_i |=> cnt_q == 11'h001)
    else $error("sync did not restart the frame position");
  chk_dup_discard: assert property (@(negedge tx_highspeed_input_clock_i) // R8
    disable iff (rst_l) bm && pos[0] && !pos[SIG_BIT] |-> !keep_pay && !keep_sig)
    else $error("duplicate slot was kept");
  chk_octet_hand: assert property (@(negedge tx_highspeed_input_clock_i) // R8
    disable iff (rst_l) done |=> tg_q[$past(ch)] != $past(tg_q[ch]))
    else $error("completed octet not handed over");
  chk_fall_capture: assert property (@(negedge tx_highspeed_input_clock_i) // R13
    disable iff (rst_l) keep_pay |=> sh_q[$past(ch)][0] == $past(tx_serial_data_in_i))
    else $error("payload bit not taken on the falling edge");
  chk_bitmux_mode: assert property (@(negedge tx_highspeed_input_clock_i) // R1
    disable iff (rst_l) keep_sig |-> cfg_q == {1'b1, MODE_BITMUX} && pos[0])
    else $error("signaling slot outside bit-multiplexed mode");
  chk_hmvip_route: assert property (@(negedge tx_highspeed_input_clock_i) // R10
    disable iff (rst_l) hm && keep_pay |-> ch == pos[5:4] && bitp == pos[3:1])
    else $error("byte-interleaved slot routed to wrong channel");
  chk_idle_mode: assert property (@(negedge tx_highspeed_input_clock_i) // R1
    disable iff (rst_l) !bm && !hm |=> $stable(tg_q))
    else $error("octet produced while multiplexed modes are off");

  // ==========================================================================
  // slot decode and keep terms checked against the stream layout
  chk_sig_capture: assert property (@(negedge tx_highspeed_input_clock_i) // R3
    disable iff (rst_l) keep_sig |=> sg_q[$past(ch)][0] == $past(tx_serial_data_in_i))
    else $error("signaling bit not taken in its slot");

  chk_bm_pay_slot: assert property (@(negedge tx_highspeed_input_clock_i) // R2
    disable iff (rst_l) bm && !pos[0] |-> keep_pay && !keep_sig)
    else $error("first copy of a payload bit was dropped");

  chk_hm_dup_drop: assert property (@(negedge tx_highspeed_input_clock_i) // R16
    disable iff (rst_l) hm && pos[0] |-> !keep_pay && !keep_sig)
    else $error("second copy kept in byte-interleaved mode");

  chk_hm_no_sig: assert property (@(negedge tx_highspeed_input_clock_i) // R10
    disable iff (rst_l) hm && done |=> os_q[$past(ch)] == 4'h0)
    else $error("signaling handed over in byte-interleaved mode");

  chk_idle_nokeep: assert property (@(negedge tx_highspeed_input_clock_i) // R1
    disable iff (rst_l) !bm && !hm |-> !keep_pay && !keep_sig && !done)
    else $error("slot kept while multiplexed modes are off");

  chk_pos_count: assert property (@(negedge tx_highspeed_input_clock_i) // R6
    disable iff (rst_l) !tx_frame_sync_in_i |=> cnt_q == 11'($past(cnt_q) + 11'h001))
    else $error("frame position did not advance");

  chk_bm_last_ch: assert property (@(negedge tx_highspeed_input_clock_i) // R8
    disable iff (rst_l) bm && done && ch == 2'h3 |-> pos[5:0] == 6'h3f)
    else $error("last channel octet closed at wrong slot");

  chk_bm_done_slot: assert property (@(negedge tx_highspeed_input_clock_i) // R8
    disable iff (rst_l) bm && done |-> pos[0] && pos[5:3] == 3'h7)
    else $error("bit-multiplexed octet closed before signaling bit D");

  chk_hm_done_slot: assert property (@(negedge tx_highspeed_input_clock_i) // R16
    disable iff (rst_l) hm && done |-> !pos[0] && pos[3:1] == 3'h7)
    else $error("byte-interleaved octet closed before its last bit");

  chk_done_kept: assert property (@(negedge tx_highspeed_input_clock_i) // R8
    disable iff (rst_l) done |-> keep_pay || keep_sig)
    else $error("octet closed on a dropped slot");
endmodule
`default_nettype wire

// File: rtl/tbd_pkg.sv
`default_nettype none
package tbd_pkg;
  // ==========================================================================
  // stream layout
  localparam int unsigned CH_N      = 4;
  localparam int unsigned CH_W      = 2;
  localparam int unsigned POS_W     = 11;  // 32 timeslots x 4 ch x 16 bit slots
  localparam int unsigned TS_W      = 5;
  localparam int unsigned OCT_W     = 8;
  localparam int unsigned SIG_W     = 4;
  localparam int unsigned BUF_DEPTH = 4;
  // ==========================================================================
  // field positions inside the stream position counter
  localparam int unsigned BM_CH_LSB  = 1;   // bit-multiplexed: channel
  localparam int unsigned BM_BIT_LSB = 3;   // bit-multiplexed: payload bit
  localparam int unsigned HM_BIT_LSB = 1;   // byte-interleaved: payload bit
  localparam int unsigned HM_CH_LSB  = 4;   // byte-interleaved: channel
  localparam int unsigned TS_LSB     = 6;
  localparam int unsigned SIG_BIT    = 5;   // bit positions 5..8 carry A..D
  // ==========================================================================
  // modes
  localparam logic [1:0] MODE_BITMUX = 2'h1;
  localparam logic [1:0] MODE_HMVIP  = 2'h2;
  localparam logic [2:0] LAST_BIT    = 3'h7;
  // ==========================================================================
  // reset value and frame timeslot
  localparam logic       IDLE_BIT    = 1'h1;
  localparam logic [TS_W-1:0] TS_FRAME = 5'h0;
endpackage
`default_nettype wire

// File: tb/tbd_demux_tb.sv
`default_nettype none
`define CHECK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end
module tbd_demux_tb
  import tbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_i = 1'b0;
  logic                  srst_i;
  logic                  enable;
  logic [1:0]            mode;
  logic                  hold_line;
  logic                  expect_notes;
  logic                  link_clk;
  logic                  ser;
  logic                  sync;
  wire logic [CH_N-1:0]  line_clk;
  logic [CH_N-1:0]       data;
  logic [CH_N*SIG_W-1:0] sig;
  logic [CH_N-1:0]       frame;
  logic [CH_N-1:0]       ovf;
  logic [CH_N-1:0]       ovf_seen = '0;
  int                    mismatches = 0;
  int                    total_checks = 0;

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) ovf_seen <= ovf_seen | (ovf & ~{CH_N{srst_i}});

  tbd_demux u_tbd_demux (
    .clk_i                       (clk_i),
    .srst_i                      (srst_i),
    .tx_mux_enable_i             (enable),
    .tx_if_mode_i                (mode),
    .tx_highspeed_input_clock_i  (link_clk),
    .tx_serial_data_in_i         (ser),
    .tx_frame_sync_in_i          (sync),
    .per_channel_tx_line_clock_i (line_clk),
    .tx_line_data_o              (data),
    .tx_line_sig_o               (sig),
    .tx_line_frame_o             (frame),
    .tx_overflow_o               (ovf)
  );
  tbd_sender u_tbd_sender (
    .mode_bitmux_i (mode == MODE_BITMUX),
    .expect_i      (expect_notes),
    .hold_line_i   (hold_line),
    .link_clk_o    (link_clk),
    .data_o        (ser),
    .sync_o        (sync),
    .line_clk_o    (line_clk)
  );
  // ==========================================================================
  // line-side monitor: an octet starts at the first 0 after idle ones
  for (genvar g = 0; g < CH_N; g++) begin : g_mon
    logic [12:0] got;
    logic [12:0] want;
    int          n = 0;
    always begin
      @(posedge line_clk[g]);
      repeat (6) @(posedge clk_i);
      if (n == 0 && data[g] === 1'b0) begin
        got = {frame[g], sig[4*g +: 4], 8'h00};
        n = 8;
      end
      if (n > 0) begin
        n--;
        got[n] = data[g];
        if (n == 0) begin
          want = 'x;
          if (u_tbd_sender.exp_q[g].size() > 0) want = u_tbd_sender.exp_q[g].pop_front();
          `CHECK(got, want)
        end
      end
    end
  end
  // ==========================================================================
  // sequence
  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_ts(input int ts);
    int i;
    for (i = 0; i < 30000 && u_tbd_sender.cur_ts != ts; i++) @(posedge clk_i);
    if (i == 30000) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic restart(input logic en, input logic [1:0] m);
    srst_i <= 1'b1;
    enable <= en;
    mode <= m;
    // long enough for the link side to see five of its own edges
    repeat (30) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask
  task automatic load(input int last);
    for (int t = 0; t <= last; t++) begin
      for (int c = 0; c < CH_N; c++) begin
        u_tbd_sender.oct_mem[t][c] = 8'($urandom()) & 8'h7f;
        u_tbd_sender.sig_mem[t][c] = 4'($urandom());
      end
      u_tbd_sender.live[t] = 1'b1;
    end
  endtask
  task automatic drained();
    for (int c = 0; c < CH_N; c++) `CHECK(u_tbd_sender.exp_q[c].size(), 0)
  endtask

  initial begin
    srst_i = 1'b1;
    enable = 1'b1;
    mode = MODE_BITMUX;
    hold_line = 1'b0;
    expect_notes = 1'b1;
    void'($urandom(32'hc1c81171));
    wait_ts(31);
    restart(1'b1, MODE_BITMUX);
    load(3);
    wait_ts(7);
    drained();
    `CHECK(ovf_seen, 4'h0)
    hold_line <= 1'b1;
    wait_ts(17);
    `CHECK(ovf_seen, 4'hf)
    hold_line <= 1'b0;
    wait_ts(31);
    restart(1'b1, MODE_HMVIP);
    load(3);
    wait_ts(7);
    drained();
    expect_notes <= 1'b0;
    restart(1'b1, 2'h0);
    load(31);
    wait_ts(11);
    restart(1'b1, 2'h3);
    wait_ts(15);
    restart(1'b0, MODE_BITMUX);
    wait_ts(19);
    foreach (u_tbd_sender.live[t]) u_tbd_sender.live[t] = 1'b0;
    conclude();
  end
endmodule
`undef CHECK
`default_nettype wire

// File: tb/tbd_sender.sv
`default_nettype none
module tbd_sender
  import tbd_pkg::*;
(
  input  wire logic            mode_bitmux_i,
  input  wire logic            expect_i,
  input  wire logic            hold_line_i,
  output logic                 link_clk_o,
  output logic                 data_o,
  output logic                 sync_o,
  output wire logic [CH_N-1:0] line_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // frame contents, loaded by the bench
  logic [OCT_W-1:0] oct_mem [32][CH_N];
  logic [SIG_W-1:0] sig_mem [32][CH_N];
  bit               live    [32];
  logic [12:0]      exp_q   [CH_N][$];
  int               cur_ts = 0;
  // ==========================================================================
  // clocks
  initial begin
    link_clk_o = 1'b0;
    #7;
    forever #15 link_clk_o = ~link_clk_o;
  end
  for (genvar g = 0; g < CH_N; g++) begin : g_line
    logic lc = 1'b0;
    // a held line clock stands low, so its buffer can only fill
    always #(50 + 2 * g) lc = hold_line_i ? 1'b0 : ~lc;
    assign line_clk_o[g] = lc;
  end
  // ==========================================================================
  // stream: frames back to back, filler octets where nothing is loaded
  initial begin
    logic [OCT_W-1:0] oct [CH_N];
    logic [SIG_W-1:0] sig [CH_N];
    logic [1:0]       ch;
    logic [2:0]       k;
    logic             b;
    data_o = 1'b1;
    sync_o = 1'b0;
    forever begin
      for (int t = 0; t < 32; t++) begin
        for (int c = 0; c < CH_N; c++) begin
          oct[c] = live[t] ? oct_mem[t][c] : 8'hff;
          sig[c] = live[t] ? sig_mem[t][c] : 4'hf;
          if (live[t] && expect_i) begin
            exp_q[c].push_back({t == 0, mode_bitmux_i ? sig[c] : 4'h0, oct[c]});
          end
        end
        live[t] = 1'b0;
        cur_ts = t;
        for (int p = 0; p < 64; p++) begin
          if (mode_bitmux_i) begin
            ch = 2'(p >> 1);
            k = 3'(p >> 3);
            b = (p[0] && k >= 3'h4) ? sig[ch][3'h7 - k] : oct[ch][3'h7 - k];
          end else begin
            ch = 2'(p >> 4);
            k = 3'(p >> 1);
            b = oct[ch][3'h7 - k];
          end
          @(posedge link_clk_o);
          data_o <= b;
          sync_o <= (t == 0 && p == 0);
        end
      end
    end
  end
endmodule
`default_nettype wire
